// ===== hdl/serial_map.svh
// Purpose: Register offsets, field positions, reset values and timing counts for the serial interface.
// Assumes: Byte-wide registers on a plain strobe port; 20 MHz clock.
// Notes: Overview follows.
`ifndef SERIAL_MAP_SVH
`define SERIAL_MAP_SVH
`define OFS_STATUS 3'h0
`define OFS_DATA 3'h1
`define OFS_CTRL_ONE 3'h2
`define OFS_CTRL_TWO 3'h3
`define OFS_BAUD 3'h4
`define OFS_FINE 3'h5
`define CTRL_ONE_RESET 8'h00
`define CTRL_TWO_RESET 8'h00
`define BAUD_RESET 8'h00
`define FINE_RESET 8'h00
`define ST_RX_FULL 5
`define ST_IDLE 4
`define ST_OVERRUN 3
`define ST_NOISE 2
`define ST_FRAMING 1
`define ST_PARITY 0
`define ST_TX_EMPTY 7
`define ST_TX_DONE 6
`define OVS_TICKS 5'h10
`define OVS_MID 5'h08
`endif

// ===== hdl/serial_pkg.sv
// Purpose: Types shared by the serial interface.
// Assumes: Constants live in serial_map.svh.
// Notes: None.
package serial_pkg;
    typedef struct packed {
        logic rd;
        logic wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
    typedef struct packed {
        logic ninth_rx;
        logic ninth_tx;
        logic low_power_disable;
        logic word_len9;
        logic wake_addr;
        logic parity_enable;
        logic parity_odd_select;
        logic parity_irq_enable;
    } ctrl_one_t;
    typedef enum logic [1:0] {TX_IDLE, TX_SEND} tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_t;
endpackage

// ===== hdl/serial_iface.sv
// Purpose: Asynchronous serial transmitter and receiver with status, control and divisor registers.
// Assumes: Plain strobe register port, read data one cycle after the read strobe.
// Notes: Receiver samples at 16 ticks per bit; transmitter shifts at one bit per 16 ticks.
`timescale 1ns/1ps
`include "serial_map.svh"
module serial_iface (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire serial_pkg::reg_req_t req,
    output logic [7:0] rdata,
    // Serial pins
    input wire logic rx_data_in,
    output logic tx_data_out,
    output logic sync_clk_out,
    // Interrupt request
    output logic irq
);
    import serial_pkg::*;

    ctrl_one_t ctrl_q;
    logic [7:0] ctrl_two_q;   // 7 tx irq,6 done irq,5 rx irq,4 idle irq,3 tx en,2 rx en,1 last pulse,0 clk en
    logic [7:0] baud_q;       // 7:6 prescaler, 5:3 tx divisor, 2:0 rx divisor
    logic [7:0] fine_q;
    logic [7:0] status_q;
    logic [7:0] rx_buf_q;
    logic [7:0] tx_hold_q;
    logic [7:0] rdata_q;
    logic status_seen_q;
    logic idle_armed_q;

    // Register decode
    wire wr_ctrl_one = req.wr && req.addr == `OFS_CTRL_ONE;
    wire wr_ctrl_two = req.wr && req.addr == `OFS_CTRL_TWO;
    wire wr_baud = req.wr && req.addr == `OFS_BAUD;
    wire wr_fine = req.wr && req.addr == `OFS_FINE;
    wire wr_data = req.wr && req.addr == `OFS_DATA;
    wire rd_status = req.rd && req.addr == `OFS_STATUS;
    wire rd_data = req.rd && req.addr == `OFS_DATA;
    wire clear_seq = rd_data && status_seen_q;

    function automatic logic [7:0] coarse_factor(input logic [1:0] code);
        case (code)
            2'h0: coarse_factor = 8'h01;
            2'h1: coarse_factor = 8'h03;
            2'h2: coarse_factor = 8'h04;
            default: coarse_factor = 8'h0d;
        endcase
    endfunction

    // Divider stop after current byte
    logic tx_busy, rx_busy, stopped_q;
    wire stopped_d = ctrl_q.low_power_disable ? (stopped_q || (!tx_busy && !rx_busy)) : 1'b0;

    // Baud tick generators, sixteenth-bit ticks
    logic [3:0] pre_cnt_q;
    logic pre_tick;
    logic [15:0] tx_div_cnt_q, rx_div_cnt_q;
    wire [7:0] pre_max = coarse_factor(baud_q[7:6]) - 8'h01;
    assign pre_tick = !stopped_q && ({4'h0, pre_cnt_q} == pre_max);
    wire [15:0] tx_pow = 16'h0001 << baud_q[5:3];
    wire [15:0] tx_total = (fine_q == 8'h00) ? tx_pow : 16'(tx_pow * {8'h00, fine_q});
    wire [15:0] rx_total = 16'h0001 << baud_q[2:0];
    wire tx_tick = pre_tick && (tx_div_cnt_q >= tx_total - 16'h0001);
    wire rx_tick = pre_tick && (rx_div_cnt_q >= rx_total - 16'h0001);

    always_ff @(posedge clock) begin
        if (rst) begin
            pre_cnt_q <= 4'h0;
            tx_div_cnt_q <= 16'h0000;
            rx_div_cnt_q <= 16'h0000;
            stopped_q <= 1'b0;
        end else begin
            stopped_q <= stopped_d;
            pre_cnt_q <= (pre_tick || stopped_q) ? 4'h0 : pre_cnt_q + 4'h1;
            if (pre_tick) begin
                tx_div_cnt_q <= tx_tick ? 16'h0000 : tx_div_cnt_q + 16'h0001;
                rx_div_cnt_q <= rx_tick ? 16'h0000 : rx_div_cnt_q + 16'h0001;
            end
        end
    end

    // Pin synchroniser
    logic rx_meta_q, rx_sync_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
        end else begin
            rx_meta_q <= rx_data_in;
            rx_sync_q <= rx_meta_q;
        end
    end

    // Transmitter
    tx_state_t tx_state_q;
    logic [10:0] tx_shift_q;
    logic [3:0] tx_bits_q;
    logic [3:0] tx_sub_q;
    logic tx_empty_q, tx_done_q, tx_line_q, sclk_q;
    logic tx_word9_q;
    wire tx_par_bit = ctrl_q.parity_odd_select ^ (^(ctrl_q.word_len9 ? tx_hold_q : {1'b0, tx_hold_q[6:0]}));
    // Top data bit replaced by parity when enabled
    wire tx_bit8 = ctrl_q.parity_enable ? tx_par_bit : ctrl_q.ninth_tx;
    wire tx_bit7 = (ctrl_q.parity_enable && !ctrl_q.word_len9) ? tx_par_bit : tx_hold_q[7];
    wire [10:0] tx_frame = ctrl_q.word_len9 ? {1'b1, tx_bit8, tx_hold_q, 1'b0}
                                            : {2'b11, tx_bit7, tx_hold_q[6:0], 1'b0};
    wire [3:0] tx_last = tx_word9_q ? 4'ha : 4'h9;
    assign tx_busy = tx_state_q == TX_SEND;
    // Frame starts on a tick so the start bit is as long as every other bit
    wire tx_load = tx_state_q == TX_IDLE && !tx_empty_q && ctrl_two_q[3] && !stopped_q && tx_tick;
    wire tx_data_bit = tx_bits_q != 4'h0 && tx_bits_q != tx_last;
    wire tx_last_data = tx_bits_q == (tx_word9_q ? 4'h9 : 4'h8);
    wire sclk_en = ctrl_two_q[0] && tx_data_bit && (!tx_last_data || ctrl_two_q[1]);

    always_ff @(posedge clock) begin
        if (rst) begin
            tx_state_q <= TX_IDLE;
            tx_shift_q <= 11'h7ff;
            tx_bits_q <= 4'h0;
            tx_sub_q <= 4'h0;
            tx_line_q <= 1'b1;
            sclk_q <= 1'b0;
            tx_word9_q <= 1'b0;
        end else begin
            case (tx_state_q)
                TX_IDLE: begin
                    tx_line_q <= 1'b1;
                    sclk_q <= 1'b0;
                    if (tx_load) begin
                        tx_shift_q <= tx_frame;
                        tx_word9_q <= ctrl_q.word_len9;
                        tx_bits_q <= 4'h0;
                        tx_sub_q <= 4'h0;
                        tx_state_q <= TX_SEND;
                    end
                end
                TX_SEND: begin
                    tx_line_q <= tx_shift_q[0];
                    if (tx_tick) begin
                        tx_sub_q <= tx_sub_q + 4'h1;
                        // Pulse ends at the bit boundary, never spills into stop
                        sclk_q <= sclk_en && tx_sub_q >= 4'h7 && tx_sub_q != 4'hf;
                        if (tx_sub_q == 4'hf) begin
                            tx_shift_q <= {1'b1, tx_shift_q[10:1]};
                            tx_bits_q <= tx_bits_q + 4'h1;
                            if (tx_bits_q == tx_last)
                                tx_state_q <= TX_IDLE;
                        end
                    end
                end
                default: tx_state_q <= TX_IDLE;
            endcase
        end
    end
    wire tx_frame_end = tx_busy && tx_tick && tx_sub_q == 4'hf && tx_bits_q == tx_last;

    always_ff @(posedge clock) begin
        if (rst) begin
            tx_empty_q <= 1'b1;
            tx_done_q <= 1'b1;
            tx_hold_q <= 8'h00;
        end else begin
            if (wr_data) begin
                tx_hold_q <= req.wdata;
                tx_empty_q <= 1'b0;
                tx_done_q <= 1'b0;
            end else if (tx_load) begin
                tx_empty_q <= 1'b1;
            end
            if (tx_frame_end)
                tx_done_q <= 1'b1;
        end
    end

    // Receiver
    rx_state_t rx_state_q;
    logic [3:0] rx_sub_q, rx_bits_q;
    logic [8:0] rx_shift_q;
    logic [2:0] rx_vote_q;
    logic rx_noise_q, rx_word9_q, rx_par_en_q, rx_par_odd_q;
    logic [3:0] idle_cnt_q;
    assign rx_busy = rx_state_q != RX_IDLE;
    wire vote = (rx_vote_q[0] & rx_vote_q[1]) | (rx_vote_q[1] & rx_vote_q[2]) | (rx_vote_q[0] & rx_vote_q[2]);
    wire vote_noisy = (rx_vote_q != 3'h0) && (rx_vote_q != 3'h7);
    wire rx_sample_end = rx_tick && rx_sub_q == 4'ha;
    wire [3:0] rx_nbits = rx_word9_q ? 4'h9 : 4'h8;
    wire rx_word_done = rx_state_q == RX_BITS && rx_sample_end && rx_bits_q == rx_nbits;
    wire [8:0] rx_word = rx_word9_q ? rx_shift_q : {1'b0, rx_shift_q[8:1]};
    wire rx_par_calc = rx_par_odd_q ^ (^rx_word);
    wire rx_par_bad = rx_par_en_q && rx_par_calc;
    wire rx_frame_bad = !vote || (rx_word == 9'h000 && !vote);
    wire overrun_now = rx_word_done && status_q[`ST_RX_FULL] && !clear_seq;
    wire idle_now = idle_cnt_q == 4'ha && rx_tick && rx_sub_q == 4'hf && !rx_busy;

    always_ff @(posedge clock) begin
        if (rst) begin
            rx_state_q <= RX_IDLE;
            rx_sub_q <= 4'h0;
            rx_bits_q <= 4'h0;
            rx_shift_q <= 9'h000;
            rx_vote_q <= 3'h7;
            rx_noise_q <= 1'b0;
            rx_word9_q <= 1'b0;
            rx_par_en_q <= 1'b0;
            rx_par_odd_q <= 1'b0;
            idle_cnt_q <= 4'h0;
        end else if (rx_tick) begin
            rx_sub_q <= rx_sub_q + 4'h1;
            if (rx_sub_q >= 4'h7 && rx_sub_q <= 4'h9)
                rx_vote_q <= {rx_vote_q[1:0], rx_sync_q};
            case (rx_state_q)
                RX_IDLE: begin
                    if (!rx_sync_q && ctrl_two_q[2] && !stopped_q) begin
                        rx_state_q <= RX_START;
                        rx_sub_q <= 4'h1;
                        rx_noise_q <= 1'b0;
                        rx_word9_q <= ctrl_q.word_len9;
                        rx_par_en_q <= ctrl_q.parity_enable;
                        rx_par_odd_q <= ctrl_q.parity_odd_select;
                        idle_cnt_q <= 4'h0;
                    end else if (rx_sub_q == 4'hf && rx_sync_q && idle_cnt_q != 4'ha) begin
                        idle_cnt_q <= idle_cnt_q + 4'h1;
                    end
                end
                RX_START: begin
                    if (rx_sub_q == 4'ha) begin
                        rx_state_q <= vote ? RX_IDLE : RX_BITS; // False start back to idle
                        rx_noise_q <= vote_noisy;
                        rx_bits_q <= 4'h0;
                    end
                end
                RX_BITS: begin
                    if (rx_sub_q == 4'ha) begin
                        rx_noise_q <= rx_noise_q | vote_noisy;
                        if (rx_bits_q == rx_nbits)
                            rx_state_q <= RX_IDLE;
                        else begin
                            rx_shift_q <= {vote, rx_shift_q[8:1]};
                            rx_bits_q <= rx_bits_q + 4'h1;
                        end
                    end
                end
                default: rx_state_q <= RX_IDLE;
            endcase
        end
    end

    // Status flags: set wins over the clear sequence
    always_ff @(posedge clock) begin
        if (rst) begin
            status_q <= 8'h00;
            rx_buf_q <= 8'h00;
            status_seen_q <= 1'b0;
            idle_armed_q <= 1'b0;
            ctrl_q <= `CTRL_ONE_RESET;
        end else begin
            if (rd_status)
                status_seen_q <= 1'b1;
            else if (rd_data)
                status_seen_q <= 1'b0;
            if (wr_ctrl_one)
                ctrl_q <= {ctrl_q.ninth_rx, req.wdata[6:0]};
            if (clear_seq)
                status_q[5:0] <= 6'h00;
            if (idle_now && idle_armed_q && !ctrl_q.wake_addr) begin
                status_q[`ST_IDLE] <= 1'b1;
                idle_armed_q <= 1'b0;
            end
            if (rx_word_done) begin
                idle_armed_q <= 1'b1;
                if (overrun_now) begin
                    status_q[`ST_OVERRUN] <= 1'b1;
                end else begin
                    rx_buf_q <= rx_word[7:0];
                    ctrl_q.ninth_rx <= rx_word[8];
                    status_q[`ST_RX_FULL] <= 1'b1;
                    status_q[`ST_NOISE] <= rx_noise_q | vote_noisy;
                    status_q[`ST_FRAMING] <= rx_frame_bad;
                    status_q[`ST_PARITY] <= rx_par_bad;
                end
            end
        end
    end

    // Other registers
    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_two_q <= `CTRL_TWO_RESET;
            baud_q <= `BAUD_RESET;
            fine_q <= `FINE_RESET;
        end else begin
            if (wr_ctrl_two)
                ctrl_two_q <= req.wdata;
            if (wr_baud)
                baud_q <= req.wdata;
            if (wr_fine)
                fine_q <= req.wdata;
        end
    end

    // Read mux
    wire [7:0] status_view = {tx_empty_q, tx_done_q, status_q[5:0]};
    wire [7:0] rd_mux = (req.addr == `OFS_STATUS) ? status_view :
                        (req.addr == `OFS_DATA) ? rx_buf_q :
                        (req.addr == `OFS_CTRL_ONE) ? ctrl_q :
                        (req.addr == `OFS_CTRL_TWO) ? ctrl_two_q :
                        (req.addr == `OFS_BAUD) ? baud_q :
                        (req.addr == `OFS_FINE) ? fine_q : 8'h00;
    // Interrupt: rx full/overrun via rx irq enable, idle, parity, tx empty, tx done; noise and framing none
    wire irq_d = (ctrl_two_q[5] && (status_q[`ST_RX_FULL] || status_q[`ST_OVERRUN])) ||
                 (ctrl_two_q[4] && status_q[`ST_IDLE]) ||
                 (ctrl_q.parity_irq_enable && status_q[`ST_PARITY]) ||
                 (ctrl_two_q[7] && tx_empty_q) || (ctrl_two_q[6] && tx_done_q);

    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_q <= 8'h00;
            irq <= 1'b0;
            tx_data_out <= 1'b1;
            sync_clk_out <= 1'b0;
        end else begin
            rdata_q <= req.rd ? rd_mux : 8'h00;
            irq <= irq_d;
            tx_data_out <= stopped_q ? 1'b1 : tx_line_q;
            sync_clk_out <= stopped_q ? 1'b0 : sclk_q;
        end
    end
    assign rdata = rdata_q;
endmodule

// ===== verification/serial_iface_checker.sv
// Purpose: Port-level assertions for the serial interface.
// Assumes: Bound to serial_iface; single clock domain.
// Notes: Helper logic measures how long the transmit line holds a level.
`timescale 1ns/1ps
`include "serial_map.svh"
module serial_iface_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire serial_pkg::reg_req_t req,
    input wire logic [7:0] rdata,
    // Serial pins and interrupt
    input wire logic rx_data_in,
    input wire logic tx_data_out,
    input wire logic sync_clk_out,
    input wire logic irq
);
    import serial_pkg::*;
    logic [15:0] run_q;
    logic [15:0] run_d;
    logic prev_q;
    logic seen_q;
    logic seen_d;
    // Length of the current level run, saturating
    assign run_d = (tx_data_out != prev_q) ? 16'h0001 : ((run_q == 16'hffff) ? run_q : run_q + 16'h0001);
    // Any clock pulse seen during the current run
    assign seen_d = (tx_data_out != prev_q) ? sync_clk_out : (seen_q | sync_clk_out);
    always_ff @(posedge clock) begin
        if (rst) begin
            run_q <= 16'h0000;
            prev_q <= 1'b1;
            seen_q <= 1'b0;
        end else begin
            run_q <= run_d;
            prev_q <= tx_data_out;
            seen_q <= seen_d;
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    sequence s_status_rd;
        req.rd && req.addr == `OFS_STATUS;
    endsequence
    sequence s_data_rd;
        req.rd && req.addr == `OFS_DATA;
    endsequence
    property p_read_quiet;
        !$past(req.rd) |-> rdata == 8'h00;
    endproperty
    property p_clear_seq;
        s_status_rd ##1 s_data_rd ##1 s_status_rd |=> rdata[5:0] == 6'h00;
    endproperty
    property p_low_whole;
        $rose(tx_data_out) |-> run_q[3:0] == 4'h0 && run_q != 16'h0000;
    endproperty
    property p_stop_full;
        $fell(tx_data_out) |-> run_q >= 16'h0010;
    endproperty
    property p_reset_idle;
        $fell(rst) |-> tx_data_out && !sync_clk_out && !irq && rdata == 8'h00;
    endproperty
    property p_sync_quiet_start;
        $fell(tx_data_out) && !seen_q |-> !sync_clk_out [*8];
    endproperty
    property p_overrun_full;
        $past(req.rd) && $past(req.addr) == `OFS_STATUS && rdata[`ST_OVERRUN] |-> rdata[`ST_RX_FULL];
    endproperty
    property p_error_full;
        $past(req.rd) && $past(req.addr) == `OFS_STATUS && (rdata[`ST_NOISE] || rdata[`ST_FRAMING])
            |-> rdata[`ST_RX_FULL];
    endproperty
    a_read_quiet: assert property (p_read_quiet)
        else $error("read data not zero outside a read answer");
    a_clear_seq: assert property (p_clear_seq)
        else $error("status flags survive the clearing sequence");
    a_low_whole: assert property (p_low_whole)
        else $error("low run on transmit line not whole bit times");
    a_stop_full: assert property (p_stop_full)
        else $error("high run before a falling edge shorter than one bit");
    a_reset_idle: assert property (p_reset_idle)
        else $error("outputs not idle after reset");
    a_sync_quiet_start: assert property (p_sync_quiet_start)
        else $error("clock pulse during start bit");
    a_overrun_full: assert property (p_overrun_full)
        else $error("overrun shown without receive full");
    a_error_full: assert property (p_error_full)
        else $error("noise or framing shown without receive full");
endmodule
bind serial_iface serial_iface_checker chk (.clock(clock), .rst(rst), .req(req), .rdata(rdata),
    .rx_data_in(rx_data_in), .tx_data_out(tx_data_out), .sync_clk_out(sync_clk_out), .irq(irq));

// ===== verification/serial_line_partner.sv
// Purpose: Far-end serial equipment that sends and captures frames.
// Assumes: Bit time given in clock cycles.
// Notes: Line idles high between frames.
`timescale 1ns/1ps
module serial_line_partner (
    // Clock
    input wire logic clock,
    // Serial lines
    output logic line_out,
    input wire logic line_in
);
    initial line_out = 1'b1;
    task automatic send_frame(input logic [8:0] bits, input int nb, input int bc, input logic stop);
        line_out <= 1'b0;
        repeat (bc) @(posedge clock);
        for (int i = 0; i < nb; i++) begin
            line_out <= bits[i];
            repeat (bc) @(posedge clock);
        end
        line_out <= stop;
        repeat (bc) @(posedge clock);
        // A high stop already idles the line; no second drive before a back-to-back frame
        if (!stop)
            line_out <= 1'b1;
    endtask
    task automatic get_frame(input int nb, input int bc, output logic [8:0] bits, output logic stop);
        int n;
        bits = 9'h000;
        n = 0;
        while (line_in !== 1'b0 && n < 30000) begin
            @(posedge clock);
            n++;
        end
        // Sample mid-bit
        repeat (bc / 2) @(posedge clock);
        for (int i = 0; i < nb; i++) begin
            repeat (bc) @(posedge clock);
            bits[i] = line_in;
        end
        repeat (bc) @(posedge clock);
        stop = line_in;
    endtask
endmodule

// ===== verification/async_serial_interface_tb_top.sv
// Purpose: Self-checking bench for the serial interface.
// Assumes: 20 MHz clock; partner model on the serial pins.
// Notes: Transmit cases come from a table plus three by hand; receive cases follow by hand.
`timescale 1ns/1ps
`include "serial_map.svh"
module async_serial_interface_tb_top;
    import serial_pkg::*;
    typedef struct {
        logic [7:0] c1, baud, fine, data;
        logic [8:0] frame;
        int nb, bc;
    } row_t;
    logic clock = 1'b0;
    logic rst = 1'b1;
    reg_req_t req = '0;
    logic [7:0] rdata;
    logic rx_line, tx_line, sclk, irq;
    logic [8:0] d, got;
    logic stp;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    row_t rows [9] = '{'{8'h00, 8'h00, 8'h00, 8'ha5, 9'h0a5, 8, 16}, '{8'h50, 8'h00, 8'h00, 8'h3c, 9'h13c, 9, 16},
        '{8'h04, 8'h00, 8'h00, 8'h83, 9'h003, 8, 16}, '{8'h06, 8'h00, 8'h00, 8'h83, 9'h083, 8, 16},
        '{8'h16, 8'h00, 8'h00, 8'h81, 9'h181, 9, 16}, '{8'h00, 8'h48, 8'h00, 8'h5a, 9'h05a, 8, 96},
        '{8'h00, 8'hc0, 8'h00, 8'h0f, 9'h00f, 8, 208}, '{8'h00, 8'h98, 8'h00, 8'hf0, 9'h0f0, 8, 512},
        '{8'h00, 8'h08, 8'h03, 8'h69, 9'h069, 8, 96}};
    always #25 clock = ~clock;
    serial_line_partner far (.clock(clock), .line_out(rx_line), .line_in(tx_line));
    serial_iface dut (.clock(clock), .rst(rst), .req(req), .rdata(rdata), .rx_data_in(rx_line),
        .tx_data_out(tx_line), .sync_clk_out(sclk), .irq(irq));
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= v;
        @(posedge clock);
        req.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [2:0] a);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge clock);
        req.rd <= 1'b0;
        #1 d = {1'b0, rdata};
    endtask
    task automatic chk(input logic [8:0] g, input logic [8:0] e);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 90000) begin
            mismatches++;
            give_verdict;
        end
    end
    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(`OFS_STATUS);
        chk(d, 9'h0c0);
        for (int k = 2; k < 8; k++) begin
            if (k == 7) wr(3'h7, 8'hff);
            rd(k[2:0]);
            chk(d, 9'h000);
        end
        wr(`OFS_CTRL_TWO, 8'h0f);
        foreach (rows[i]) begin
            wr(`OFS_CTRL_ONE, rows[i].c1);
            wr(`OFS_BAUD, rows[i].baud);
            wr(`OFS_FINE, rows[i].fine);
            fork
                far.get_frame(rows[i].nb, rows[i].bc, got, stp);
                wr(`OFS_DATA, rows[i].data);
            join
            chk(got, rows[i].frame);
            chk({8'h00, stp}, 9'h001);
            repeat (rows[i].bc) @(posedge clock);
        end
        wr(`OFS_BAUD, 8'h00);
        wr(`OFS_FINE, 8'h00);
        wr(`OFS_CTRL_ONE, 8'h00);
        fork
            far.get_frame(8, 16, got, stp);
            begin
                wr(`OFS_DATA, 8'h83);
                repeat (40) @(posedge clock);
                wr(`OFS_CTRL_ONE, 8'h04);
            end
        join
        chk(got, 9'h083);
        repeat (16) @(posedge clock);
        fork
            far.get_frame(8, 16, got, stp);
            wr(`OFS_DATA, 8'h83);
        join
        chk(got, 9'h003);
        repeat (16) @(posedge clock);
        wr(`OFS_CTRL_TWO, 8'h0c);
        wr(`OFS_CTRL_ONE, 8'h10);
        far.send_frame(9'h1a5, 9, 16, 1'b1);
        repeat (4) @(posedge clock);
        rd(`OFS_STATUS);
        chk(d & 9'h03f, 9'h020);
        rd(`OFS_STATUS);
        rd(`OFS_DATA);
        chk(d, 9'h0a5);
        rd(`OFS_STATUS);
        chk(d & 9'h03f, 9'h000);
        rd(`OFS_CTRL_ONE);
        chk(d, 9'h090);
        wr(`OFS_CTRL_ONE, 8'h05);
        far.send_frame(9'h001, 8, 16, 1'b1);
        repeat (4) @(posedge clock);
        chk({8'h00, irq}, 9'h001);
        rd(`OFS_STATUS);
        chk(d & 9'h03f, 9'h021);
        rd(`OFS_DATA);
        repeat (2) @(posedge clock);
        chk({8'h00, irq}, 9'h000);
        wr(`OFS_CTRL_ONE, 8'h00);
        wr(`OFS_CTRL_TWO, 8'h1c);
        far.send_frame(9'h033, 8, 16, 1'b0);
        repeat (4) @(posedge clock);
        rd(`OFS_STATUS);
        chk(d & 9'h03f, 9'h022);
        rd(`OFS_DATA);
        repeat (200) @(posedge clock);
        chk({8'h00, irq}, 9'h001);
        rd(`OFS_STATUS);
        chk(d & 9'h010, 9'h010);
        rd(`OFS_DATA);
        repeat (200) @(posedge clock);
        chk({8'h00, irq}, 9'h000);
        rd(`OFS_STATUS);
        chk(d & 9'h010, 9'h000);
        wr(`OFS_CTRL_TWO, 8'h2c);
        far.send_frame(9'h011, 8, 16, 1'b1);
        far.send_frame(9'h022, 8, 16, 1'b0);
        repeat (4) @(posedge clock);
        chk({8'h00, irq}, 9'h001);
        rd(`OFS_STATUS);
        chk(d & 9'h03f, 9'h028);
        rd(`OFS_DATA);
        chk(d, 9'h011);
        // Receive divisor 2 and address-mark wake-up: no idle flag afterwards
        wr(`OFS_CTRL_ONE, 8'h08);
        wr(`OFS_BAUD, 8'h01);
        far.send_frame(9'h05c, 8, 32, 1'b1);
        repeat (8) @(posedge clock);
        rd(`OFS_STATUS);
        chk(d & 9'h03f, 9'h020);
        rd(`OFS_DATA);
        chk(d, 9'h05c);
        repeat (400) @(posedge clock);
        rd(`OFS_STATUS);
        chk(d & 9'h010, 9'h000);
        wr(`OFS_CTRL_TWO, 8'h0c);
        wr(`OFS_CTRL_ONE, 8'h20);
        wr(`OFS_DATA, 8'h00);
        got = 9'h000;
        repeat (400) begin
            @(posedge clock);
            got = got | {8'h00, ~tx_line};
        end
        chk(got, 9'h000);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(`OFS_CTRL_ONE);
        chk(d, 9'h000);
        chk({8'h00, tx_line}, 9'h001);
        give_verdict;
    end
endmodule
